// ### rfe_estimator.v
// rotor flux angle estimator: current model, angle integrator, sine/cosine
// How it works
// - magnetizing current steps toward d current by gain; slip = q over it, times gain
// - zero magnetizing current skips the division and forces the quotient to zero
// - flux speed in 4.12 is rotor speed plus the scaled slip term
// - flux angle is a 16 bit unsigned word wrapping on overflow and underflow
// - increment is |flux speed| times angle constant, added or subtracted by sign
// - a view copy of the angle shifted right by four is output, unused inside
// - one full sine period sits in a 256 entry 4.12 table
// - table index is the upper byte of the 16 bit angle
// - table entry at that index is the angle sine in 4.12
// - cosine reads the table at index plus a quarter period, wrapped to 8 bits
`timescale 1ns/100ps
`include "rfe_regs.vh"

module rfe_estimator #(
  parameter [15:0] KMAG   = `RFE_KMAG,
  parameter [15:0] KSLIP  = `RFE_KSLIP,
  parameter [15:0] KANGLE = `RFE_KANGLE,
  parameter        DEPTH  = 4,
  parameter        AW     = 2
) (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        in_valid,
  output wire        in_ready,
  input  wire [15:0] direct_axis_current,
  input  wire [15:0] quadrature_axis_current,
  input  wire [15:0] rotor_speed,
  output wire        out_valid,
  input  wire        out_ready,
  output reg  [15:0] flux_angle,
  output reg  [15:0] flux_angle_view,
  output reg  [15:0] flux_speed,
  output reg  [15:0] magnetizing_current,
  output wire [15:0] angle_sine,
  output wire [15:0] angle_cosine
);

  // ---------------------------------------------------------------------------
  // states
  // ---------------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_MAG  = 3'h1;
  localparam [2:0] S_DIV  = 3'h2;
  localparam [2:0] S_SLIP = 3'h3;
  localparam [2:0] S_ANG  = 3'h4;
  localparam [2:0] S_TRIG = 3'h5;
  localparam [2:0] S_OUT  = 3'h6;

  // ---------------------------------------------------------------------------
  // arithmetic helpers
  // ---------------------------------------------------------------------------
  // 4.12 times 4.12, keeping the middle word like a shift-by-four store
  function [15:0] mul_q12;
    input [15:0] a;
    input [15:0] b;
    reg   signed [31:0] p;
    begin
      p = $signed(a) * $signed(b);
      mul_q12 = p[`RFE_FRAC_BITS+15:`RFE_FRAC_BITS];
    end
  endfunction

  // two's complement magnitude; the most negative code stays as it is
  function [15:0] mag16;
    input [15:0] v;
    begin
      if (v[15])
        mag16 = 16'h0000 - v;
      else
        mag16 = v;
    end
  endfunction

  // ---------------------------------------------------------------------------
  // input buffer
  // ---------------------------------------------------------------------------
  wire        fifo_valid;
  wire        fifo_pop;
  wire [47:0] fifo_data;

  rfe_fifo #(
    .W  (48),
    .D  (DEPTH),
    .AW (AW)
  ) u_fifo (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .wr_valid (in_valid),
    .wr_ready (in_ready),
    .wr_data  ({direct_axis_current, quadrature_axis_current, rotor_speed}),
    .rd_valid (fifo_valid),
    .rd_ready (fifo_pop),
    .rd_data  (fifo_data)
  );

  // ---------------------------------------------------------------------------
  // state and working registers
  // ---------------------------------------------------------------------------
  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg [15:0] id_r;
  reg [15:0] iq_r;
  reg [15:0] spd_r;
  reg [31:0] acc_r;
  reg [31:0] acc_nxt;
  reg [4:0]  step_r;
  reg [4:0]  step_nxt;
  reg [15:0] mag_nxt;
  reg [15:0] fs_nxt;
  reg [15:0] ang_nxt;
  reg [15:0] quot;
  reg [15:0] incr;
  reg [31:0] diff;

  assign fifo_pop  = (state_r == S_IDLE);
  assign out_valid = (state_r == S_OUT);

  // ---------------------------------------------------------------------------
  // sine table
  // ---------------------------------------------------------------------------
  wire [7:0] sin_idx = flux_angle[15:`RFE_IDX_SHIFT];
  wire [7:0] cos_idx = sin_idx + `RFE_COS_OFFSET;

  rfe_sine_rom u_rom (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .addr_a  (sin_idx),
    .addr_b  (cos_idx),
    .data_a  (angle_sine),
    .data_b  (angle_cosine)
  );

  // ---------------------------------------------------------------------------
  // next state and datapath
  // ---------------------------------------------------------------------------
  always @* begin
    state_nxt = state_r;
    acc_nxt   = acc_r;
    step_nxt  = step_r;
    mag_nxt   = magnetizing_current;
    fs_nxt    = flux_speed;
    ang_nxt   = flux_angle;
    quot      = 16'h0000;
    incr      = 16'h0000;
    diff      = acc_r - {1'b0, magnetizing_current, 15'h0000};
    case (state_r)
      S_IDLE: begin
        if (fifo_valid)
          state_nxt = S_MAG;
      end
      S_MAG: begin
        // the difference wraps to 16 bits before scaling, as a word store would
        mag_nxt = magnetizing_current
                + mul_q12(id_r - magnetizing_current, KMAG);
        step_nxt = 5'h00;
        if (mag_nxt == 16'h0000) begin
          acc_nxt   = 32'h0000_0000;
          state_nxt = S_SLIP;
        end else begin
          acc_nxt   = {4'h0, mag16(iq_r), 12'h000};
          state_nxt = S_DIV;
        end
      end
      S_DIV: begin
        // one conditional subtract per cycle, quotient bits enter at the bottom
        if (!diff[31])
          acc_nxt = {diff[30:0], 1'b1};
        else
          acc_nxt = {acc_r[30:0], 1'b0};
        step_nxt = step_r + 1'b1;
        if (step_r == `RFE_DIV_STEPS - 1'b1)
          state_nxt = S_SLIP;
      end
      S_SLIP: begin
        if ($signed(iq_r) > $signed(16'h0000))
          quot = acc_r[15:0];
        else
          quot = 16'h0000 - acc_r[15:0];
        fs_nxt    = spd_r + mul_q12(quot, KSLIP);
        state_nxt = S_ANG;
      end
      S_ANG: begin
        incr = mul_q12(mag16(flux_speed), KANGLE);
        if (flux_speed[15])
          ang_nxt = flux_angle - incr;
        else
          ang_nxt = flux_angle + incr;
        state_nxt = S_TRIG;
      end
      S_TRIG: begin
        // one cycle for the registered table ports to follow the new angle
        state_nxt = S_OUT;
      end
      S_OUT: begin
        if (out_ready)
          state_nxt = S_IDLE;
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------------------
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      state_r             <= S_IDLE;
      id_r                <= 16'h0000;
      iq_r                <= 16'h0000;
      spd_r               <= 16'h0000;
      acc_r               <= 32'h0000_0000;
      step_r              <= 5'h00;
      magnetizing_current <= `RFE_MAG_RST;
      flux_speed          <= 16'h0000;
      flux_angle          <= `RFE_ANGLE_RST;
      flux_angle_view     <= `RFE_ANGLE_RST;
    end else begin
      state_r             <= state_nxt;
      acc_r               <= acc_nxt;
      step_r              <= step_nxt;
      magnetizing_current <= mag_nxt;
      flux_speed          <= fs_nxt;
      flux_angle          <= ang_nxt;
      flux_angle_view     <= ang_nxt >> `RFE_VIEW_SHIFT;
      if (state_r == S_IDLE && fifo_valid) begin
        id_r  <= fifo_data[47:32];
        iq_r  <= fifo_data[31:16];
        spd_r <= fifo_data[15:0];
      end
    end
  end

endmodule

// ### rfe_estimator_assertions.sv
// checker on the estimator's top ports
`timescale 1ns/100ps
module rfe_chk #(
  parameter [15:0] KANGLE = 16'h0148
) (
  input logic        clk_sys,
  input logic        nrst,
  input logic        out_valid,
  input logic        out_ready,
  input logic [15:0] flux_angle,
  input logic [15:0] flux_angle_view,
  input logic [15:0] flux_speed,
  input logic [15:0] angle_sine,
  input logic [15:0] angle_cosine
);
  // ----------------------------------------
  // helpers and properties
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  logic [15:0]        last_r;
  wire [15:0]         abs_w  = flux_speed[15] ? -flux_speed : flux_speed;
  wire signed [31:0]  inc_w  = $signed(abs_w) * $signed(KANGLE);
  wire [15:0]         step_w = inc_w[27:12];
  // rounded table entries leave a small error on sin^2 + cos^2
  wire signed [31:0]  norm_w = $signed(angle_sine) * $signed(angle_sine)
                             + $signed(angle_cosine) * $signed(angle_cosine) - 32'sd16777216;
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst)
      last_r <= 16'h0000;
    else if (out_valid && out_ready)
      last_r <= flux_angle;
  end
  sequence s_accept; out_valid && out_ready; endsequence
  sequence s_stall; out_valid && !out_ready; endsequence
  sequence s_quiet; !out_valid [*4]; endsequence
  a_gap_after_accept: assert property (s_accept |=> s_quiet)
    else $error("result raised too soon after accept");
  a_hold_on_stall: assert property (s_stall |=> out_valid && $stable({flux_angle,
    flux_angle_view, flux_speed, angle_sine, angle_cosine})) else $error("result moved on stall");
  a_drop_after_accept: assert property ($fell(out_valid) |-> $past(out_ready))
    else $error("valid dropped without accept");
  a_view_shift: assert property (out_valid |-> flux_angle_view == {4'h0, flux_angle[15:4]})
    else $error("view copy wrong");
  a_angle_step: assert property ($rose(out_valid) |-> flux_angle ==
    (flux_speed[15] ? last_r - step_w : last_r + step_w)) else $error("angle step wrong");
  a_index_zero: assert property (out_valid && flux_angle[15:8] == 8'h00 |->
    angle_sine == 16'h0000 && angle_cosine == 16'h1000) else $error("sine at zero wrong");
  a_sine_bound: assert property (out_valid |->
    $signed(angle_sine) <= 4096 && $signed(angle_sine) >= -4096) else $error("sine range");
  a_unit_circle: assert property (out_valid |-> norm_w < 9000 && norm_w > -9000)
    else $error("cosine not in quadrature");
endmodule
bind rfe_estimator rfe_chk #(.KANGLE(KANGLE)) u_rfe_chk (.clk_sys(clk_sys), .nrst(nrst),
  .out_valid(out_valid), .out_ready(out_ready), .flux_angle(flux_angle),
  .flux_angle_view(flux_angle_view), .flux_speed(flux_speed), .angle_sine(angle_sine),
  .angle_cosine(angle_cosine));

// ### rfe_fifo.v
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps

module rfe_fifo #(
  parameter W  = 48,
  parameter D  = 4,
  parameter AW = 2
) (
  input  wire         clk_sys,
  input  wire         nrst,
  input  wire         wr_valid,
  output wire         wr_ready,
  input  wire [W-1:0] wr_data,
  output wire         rd_valid,
  input  wire         rd_ready,
  output wire [W-1:0] rd_data
);

  reg [W-1:0]  mem_r [0:D-1];
  reg [AW-1:0] wp_r;
  reg [AW-1:0] rp_r;
  reg [AW:0]   cnt_r;

  wire push = wr_valid && wr_ready;
  wire pop  = rd_valid && rd_ready;

  // full and empty come straight from the count, so they never lie
  assign wr_ready = (cnt_r != D[AW:0]);
  assign rd_valid = (cnt_r != {(AW+1){1'b0}});
  assign rd_data  = mem_r[rp_r];

  function [AW-1:0] inc_ptr;
    input [AW-1:0] p;
    begin
      if (p == D[AW-1:0] - 1'b1)
        inc_ptr = {AW{1'b0}};
      else
        inc_ptr = p + 1'b1;
    end
  endfunction

  always @(posedge clk_sys) begin
    if (push)
      mem_r[wp_r] <= wr_data;
  end

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wp_r  <= {AW{1'b0}};
      rp_r  <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push)
        wp_r <= inc_ptr(wp_r);
      if (pop)
        rp_r <= inc_ptr(rp_r);
      if (push && !pop)
        cnt_r <= cnt_r + 1'b1;
      else if (pop && !push)
        cnt_r <= cnt_r - 1'b1;
    end
  end

endmodule

// ### rfe_regs.vh
// constants for the rotor flux angle estimator
`ifndef RFE_REGS_VH
`define RFE_REGS_VH

// ----------------------------------------------------------------------------
// fixed point and gains
// ----------------------------------------------------------------------------
`define RFE_FRAC_BITS    12
`define RFE_KMAG         16'h000e
`define RFE_KSLIP        16'h01b0
`define RFE_KANGLE       16'h0148

// ----------------------------------------------------------------------------
// angle, table and divider handling
// ----------------------------------------------------------------------------
`define RFE_VIEW_SHIFT   4
`define RFE_IDX_SHIFT    8
`define RFE_COS_OFFSET   8'h40
`define RFE_DIV_STEPS    5'h10

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define RFE_MAG_RST      16'h0000
`define RFE_ANGLE_RST    16'h0000

`endif

// ### rfe_sine_rom.v
// 256 entry sine table, two registered read ports
`timescale 1ns/100ps

module rfe_sine_rom (
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire [7:0]  addr_a,
  input  wire [7:0]  addr_b,
  output reg  [15:0] data_a,
  output reg  [15:0] data_b
);

  // ---------------------------------------------------------------------------
  // quarter wave, entry 63 in the top word; the other three quarters are
  // folded from it, which keeps the full period at a quarter of the area
  // ---------------------------------------------------------------------------
  localparam [1023:0] QTAB = {
    64'h0fff0ffb0ff50fec, 64'h0fe10fd40fc40fb1, 64'h0f9c0f850f6c0f50,
    64'h0f310f110eee0ec8, 64'h0ea10e770e4b0e1c, 64'h0dec0db90d850d4e,
    64'h0d150cda0c9d0c5e, 64'h0c1e0bdb0b970b50, 64'h0b080abf0a730a26,
    64'h09d80988093708e4, 64'h088f083a07e3078b, 64'h073206d7067c061f,
    64'h05c20564050504a5, 64'h044403e30381031f, 64'h02bc025901f50191,
    64'h012d00c900650000
  };

  function [15:0] sine_of;
    input [7:0] p;
    reg   [5:0] k;
    reg   [15:0] m;
    begin
      k = p[5:0];
      m = 16'h0000;
      if (p[6] && k == 6'h00)
        m = 16'h1000;
      else if (p[6])
        m = QTAB[(6'h00 - k) * 16 +: 16];
      else
        m = QTAB[k * 16 +: 16];
      if (p[7])
        sine_of = 16'h0000 - m;
      else
        sine_of = m;
    end
  endfunction

  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      data_a <= 16'h0000;
      data_b <= 16'h0000;
    end else begin
      data_a <= sine_of(addr_a);
      data_b <= sine_of(addr_b);
    end
  end

endmodule

// ### rfe_sink.sv
// downstream consumer of results, prompt or randomly stalling
`timescale 1ns/100ps
module rfe_sink (
  input  logic clk_sys,
  input  logic nrst,
  input  logic slow,
  output logic out_ready
);
  // ----------------------------------------
  // ready generation
  // ----------------------------------------
  initial out_ready = 1'b0;
  // slow mode stalls three cycles in four so the input fifo backs up
  always @(posedge clk_sys) begin
    out_ready <= #1 nrst && (!slow || ($urandom % 4 == 0));
  end
endmodule

// ### testbench.sv
// self-checking bench for the rotor flux angle estimator
`timescale 1ns/100ps
`include "rfe_regs.vh"
module testbench;
  // ----------------------------------------
  // signals, design and sink
  // ----------------------------------------
  logic        clk_sys, nrst, in_valid, in_ready, out_valid, out_ready, slow;
  logic [15:0] d_in, q_in, s_in, ang, view, fs, mag, sn, cs, m_mag, m_ang;
  logic [95:0] exp_q[$];
  int          errors, compares;
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  rfe_estimator u_rfe_estimator (.clk_sys(clk_sys), .nrst(nrst), .in_valid(in_valid),
    .in_ready(in_ready), .direct_axis_current(d_in), .quadrature_axis_current(q_in),
    .rotor_speed(s_in), .out_valid(out_valid), .out_ready(out_ready), .flux_angle(ang),
    .flux_angle_view(view), .flux_speed(fs), .magnetizing_current(mag),
    .angle_sine(sn), .angle_cosine(cs));
  rfe_sink u_rfe_sink (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .out_ready(out_ready));
  // ----------------------------------------
  // reference model and tasks
  // ----------------------------------------
  function automatic logic [15:0] mul(input logic [15:0] a, input logic [15:0] b);
    logic signed [31:0] p;
    p = $signed(a) * $signed(b);
    return p[27:12];
  endfunction
  function automatic logic [15:0] tab(input logic [7:0] k);
    return 16'(int'(4096.0 * $sin(6.283185307179586 * k / 256.0)));
  endfunction
  function automatic logic [15:0] quot(input logic [15:0] q, input logic [15:0] m);
    logic [31:0] acc, df;
    acc = {4'h0, (q[15] ? -q : q), 12'h000};
    for (int i = 0; i < 16; i++) begin
      df = acc - {1'b0, m, 15'h0000};
      acc = df[31] ? acc << 1 : (df << 1) | 32'h1;
    end
    return ($signed(q) > 0) ? acc[15:0] : -acc[15:0];
  endfunction
  task automatic wrap_up();
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [95:0] seen, input logic [95:0] want);
    compares++;
    if (seen !== want) begin
      errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // called just after an edge; returns just after the first edge that finds in_ready high, which is the edge that takes the sample
  task automatic send(input logic [15:0] d, input logic [15:0] q, input logic [15:0] s);
    logic [15:0] qt, f, inc;
    m_mag = m_mag + mul(`RFE_KMAG, d - m_mag);
    qt = (m_mag == 16'h0000) ? 16'h0000 : quot(q, m_mag);
    f = s + mul(`RFE_KSLIP, qt);
    inc = mul(f[15] ? -f : f, `RFE_KANGLE);
    m_ang = f[15] ? m_ang - inc : m_ang + inc;
    exp_q.push_back({m_ang, m_ang >> 4, f, m_mag, tab(m_ang[15:8]), tab(m_ang[15:8] + 8'h40)});
    in_valid = 1'b1;
    d_in = d;
    q_in = q;
    s_in = s;
    for (int n = 0; n <= 400; n++) begin
      @(posedge clk_sys);
      if (in_ready === 1'b1)
        break;
      if (n == 400) begin
        errors++;
        wrap_up();
      end
    end
    #1;
  endtask
  always @(posedge clk_sys) begin
    // a result with no note behind it must fail even if it happens to read as zero
    if (nrst === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1 && exp_q.size() == 0)
      errors++;
    if (nrst === 1'b1 && out_valid === 1'b1 && out_ready === 1'b1)
      check({ang, view, fs, mag, sn, cs}, exp_q.size() ? exp_q.pop_front() : 96'h0);
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(3));
    {nrst, in_valid, slow, d_in, q_in, s_in, m_mag, m_ang} = '0;
    errors = 0;
    compares = 0;
    repeat (5) @(posedge clk_sys);
    #1 nrst = 1'b1;
    // zero magnetizing current first, then zero and most negative q
    send(16'h0000, 16'h1000, 16'h0000);
    send(16'h7fff, 16'h0000, 16'h1000);
    send(16'h7fff, 16'h8000, 16'hf000);
    for (int i = 0; i < 60; i++) begin
      slow = (i >= 30);
      send(16'($urandom), 16'($urandom), 16'($urandom));
    end
    in_valid = 1'b0;
    for (int n = 0; n < 8000 && exp_q.size() > 0; n++)
      @(posedge clk_sys);
    #1;
    if (exp_q.size() > 0)
      errors++;
    wrap_up();
  end
endmodule
